// File: rtl/asr_bank.sv
// read-only status register bank with byte read port
`timescale 1ns/100ps
//
// Function
// - every reserved bit in these registers reads as zero.
// - bit 2 of the operating state register reads 1 while the link is fast.
// - bits 1-0 report 00 manual, 10 autonomous, 11 precision, never 01.
// - the five-bit fill count reports 0 to 16 filled buffer entries.
// - bits 3-0 report accumulations done as of the last finished conversion.
// - bit 4 of the alarm source holds the channel that alarmed first; bits 7-5 read zero.
// - scan state bits 2-1 read 00 off, 01 on, 11 on with error, never 10.
// - channel zero sum reads low byte at 8h and high byte at 9h, reset zero.
// - channel one sum low byte reads at Ah, read-only, reset zero.
// - channel one sum high byte reads at Bh, read-only, reset zero.
module asr_bank (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic soft_rst_in,
  input wire asr_pkg::asr_status_t status_in,
  input wire logic rd_en_in,
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out
);
  logic clr;
  logic [7:0] op_state_r;
  logic [7:0] buf_fill_r;
  logic [7:0] sum_prog_r;
  logic [7:0] first_alarm_r;
  logic [7:0] scan_state_r;
  logic [15:0] ch0_sum_r;
  logic [15:0] ch1_sum_r;
  logic alarm_held_r;
  logic [7:0] rd_nxt;

  assign clr = rst_in | soft_rst_in;

  // ----------------------------------------------------------------
  // status capture
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (clr) begin
      op_state_r <= asr_pkg::RST_BYTE;
    end else begin
      op_state_r <= asr_pkg::RST_BYTE;
      op_state_r[asr_pkg::FAST_LINK_POS] <= status_in.fast_link_flag;
      if (status_in.operating_state_code != asr_pkg::ASR_OP_UNUSED) begin
        op_state_r[1:0] <= status_in.operating_state_code;
      end else begin
        op_state_r[1:0] <= op_state_r[1:0];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (clr) begin
      buf_fill_r <= asr_pkg::RST_BYTE;
    end else if (status_in.buffer_fill_count > asr_pkg::BUF_FILL_MAX) begin
      buf_fill_r <= {3'h0, asr_pkg::BUF_FILL_MAX};
    end else begin
      buf_fill_r <= {3'h0, status_in.buffer_fill_count};
    end
  end

  always_ff @(posedge clock_in) begin
    if (clr) begin
      sum_prog_r <= asr_pkg::RST_BYTE;
      ch0_sum_r <= {2{asr_pkg::RST_BYTE}};
      ch1_sum_r <= {2{asr_pkg::RST_BYTE}};
    end else if (status_in.sum_done) begin
      sum_prog_r <= {4'h0, status_in.sum_count};
      ch0_sum_r <= status_in.chan0_sum;
      ch1_sum_r <= status_in.chan1_sum;
    end
  end

  always_ff @(posedge clock_in) begin
    if (clr) begin
      first_alarm_r <= asr_pkg::RST_BYTE;
      alarm_held_r <= 1'h0;
    end else if (status_in.alarm_event && !alarm_held_r) begin
      first_alarm_r <= asr_pkg::RST_BYTE;
      first_alarm_r[asr_pkg::ALARM_CH_POS] <= status_in.alarm_channel;
      alarm_held_r <= 1'h1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (clr) begin
      scan_state_r <= asr_pkg::RST_BYTE;
    end else begin
      scan_state_r <= asr_pkg::RST_BYTE;
      if (!status_in.scan_enabled) begin
        scan_state_r[asr_pkg::SCAN_POS +: 2] <= asr_pkg::ASR_SCAN_OFF;
      end else if (status_in.scan_error) begin
        scan_state_r[asr_pkg::SCAN_POS +: 2] <= asr_pkg::ASR_SCAN_ERR;
      end else begin
        scan_state_r[asr_pkg::SCAN_POS +: 2] <= asr_pkg::ASR_SCAN_ON;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port; writes have no path into any register
  // ----------------------------------------------------------------
  always_comb begin
    case (addr_in)
      asr_pkg::OFF_OP_STATE: rd_nxt = op_state_r;
      asr_pkg::OFF_BUF_FILL: rd_nxt = buf_fill_r;
      asr_pkg::OFF_SUM_PROG: rd_nxt = sum_prog_r;
      asr_pkg::OFF_FIRST_ALARM: rd_nxt = first_alarm_r;
      asr_pkg::OFF_SCAN_STATE: rd_nxt = scan_state_r;
      asr_pkg::OFF_CH0_LOW: rd_nxt = ch0_sum_r[7:0];
      asr_pkg::OFF_CH0_HIGH: rd_nxt = ch0_sum_r[15:8];
      asr_pkg::OFF_CH1_LOW: rd_nxt = ch1_sum_r[7:0];
      asr_pkg::OFF_CH1_HIGH: rd_nxt = ch1_sum_r[15:8];
      default: rd_nxt = asr_pkg::RST_BYTE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_data_out <= asr_pkg::RST_BYTE;
      rd_valid_out <= 1'h0;
    end else begin
      rd_valid_out <= rd_en_in && !wr_en_in;
      rd_data_out <= (rd_en_in && !wr_en_in) ? rd_nxt : asr_pkg::RST_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence rd_of(logic [7:0] a);
    rd_en_in && !wr_en_in && addr_in == a;
  endsequence

  sequence quiet2;
    !soft_rst_in ##1 !soft_rst_in;
  endsequence

  op_reserved_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    op_state_r[7:3] == 5'h00 && scan_state_r[0] == 1'h0)
    else $error("reserved status bits not zero");
  bits_reserved_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    buf_fill_r[7:5] == 3'h0 && sum_prog_r[7:4] == 4'h0
    && first_alarm_r[3:0] == 4'h0 && scan_state_r[7:3] == 5'h00)
    else $error("reserved status bits not zero");
  fast_link_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    quiet2 |-> op_state_r[2] == $past(status_in.fast_link_flag))
    else $error("fast link bit wrong");
  op_read_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    rd_of(asr_pkg::OFF_OP_STATE) |=>
    rd_valid_out && rd_data_out == $past(op_state_r))
    else $error("operating state read wrong");
  op_code_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    op_state_r[1:0] != 2'h1)
    else $error("unused operating code reported");
  op_hold_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    status_in.operating_state_code == asr_pkg::ASR_OP_UNUSED
    && !soft_rst_in |=> $stable(op_state_r[1:0]))
    else $error("operating code not held");
  fill_range_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    buf_fill_r <= 8'h10)
    else $error("fill count above sixteen");
  fill_follow_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    quiet2 |-> buf_fill_r[4:0] ==
    ($past(status_in.buffer_fill_count) > asr_pkg::BUF_FILL_MAX
    ? asr_pkg::BUF_FILL_MAX : $past(status_in.buffer_fill_count)))
    else $error("fill count not followed");
  sum_count_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    status_in.sum_done && !soft_rst_in |=>
    sum_prog_r[3:0] == $past(status_in.sum_count))
    else $error("sum count not captured");
  alarm_first_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    status_in.alarm_event && !alarm_held_r && !soft_rst_in |=>
    first_alarm_r == {3'h0, $past(status_in.alarm_channel), 4'h0})
    else $error("first alarm channel not captured");
  alarm_hold_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    alarm_held_r && !soft_rst_in |=> $stable(first_alarm_r))
    else $error("first alarm channel overwritten");
  alarm_read_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    rd_of(asr_pkg::OFF_FIRST_ALARM) |=>
    rd_valid_out && rd_data_out == $past(first_alarm_r))
    else $error("alarm source read wrong");
  scan_code_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    scan_state_r[2:1] != 2'h2)
    else $error("unused scan code reported");
  scan_follow_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    quiet2 |-> scan_state_r[2:1] ==
    (!$past(status_in.scan_enabled) ? 2'h0
    : ($past(status_in.scan_error) ? 2'h3 : 2'h1)))
    else $error("scan state not followed");
  ch0_low_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    rd_of(asr_pkg::OFF_CH0_LOW) |=>
    rd_valid_out && rd_data_out == $past(ch0_sum_r[7:0]))
    else $error("channel zero low byte wrong");
  ch0_high_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    rd_of(asr_pkg::OFF_CH0_HIGH) |=>
    rd_valid_out && rd_data_out == $past(ch0_sum_r[15:8]))
    else $error("channel zero high byte wrong");
  sum_latch_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    status_in.sum_done && !soft_rst_in |=>
    ch0_sum_r == $past(status_in.chan0_sum)
    && ch1_sum_r == $past(status_in.chan1_sum))
    else $error("channel sums not captured");
  ch1_low_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    rd_of(asr_pkg::OFF_CH1_LOW) |=>
    rd_valid_out && rd_data_out == $past(ch1_sum_r[7:0]))
    else $error("channel one low byte wrong");
  ch1_high_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    rd_of(asr_pkg::OFF_CH1_HIGH) |=>
    rd_valid_out && rd_data_out == $past(ch1_sum_r[15:8]))
    else $error("channel one high byte wrong");
  write_ignored_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    wr_en_in |=> !rd_valid_out)
    else $error("write produced a read answer");
  idle_read_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    !(rd_en_in && !wr_en_in) |=>
    !rd_valid_out && rd_data_out == 8'h00)
    else $error("read port not idle");
  soft_clear_a: assert property
    (@(posedge clock_in) disable iff (rst_in)
    soft_rst_in |=> op_state_r == 8'h00 && buf_fill_r == 8'h00
    && sum_prog_r == 8'h00 && first_alarm_r == 8'h00
    && scan_state_r == 8'h00 && ch0_sum_r == 16'h0000
    && ch1_sum_r == 16'h0000)
    else $error("soft reset left status set");
endmodule : asr_bank

// File: rtl/asr_pkg.sv
// package for the status readback bank: offsets, layouts, codes
package asr_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_OP_STATE = 8'h00;
  localparam logic [7:0] OFF_BUF_FILL = 8'h01;
  localparam logic [7:0] OFF_SUM_PROG = 8'h02;
  localparam logic [7:0] OFF_FIRST_ALARM = 8'h03;
  localparam logic [7:0] OFF_SCAN_STATE = 8'h04;
  localparam logic [7:0] OFF_CH0_LOW = 8'h08;
  localparam logic [7:0] OFF_CH0_HIGH = 8'h09;
  localparam logic [7:0] OFF_CH1_LOW = 8'h0A;
  localparam logic [7:0] OFF_CH1_HIGH = 8'h0B;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FAST_LINK_POS = 2;
  localparam int ALARM_CH_POS = 4;
  localparam int SCAN_POS = 1;
  // ----------------------------------------------------------------
  // reset value and fill count limit
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] BUF_FILL_MAX = 5'h10;
  // ----------------------------------------------------------------
  // operating state codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASR_OP_MANUAL = 2'h0,
    ASR_OP_UNUSED = 2'h1,
    ASR_OP_AUTO = 2'h2,
    ASR_OP_PRECISE = 2'h3
  } asr_op_t;
  // ----------------------------------------------------------------
  // scan state codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASR_SCAN_OFF = 2'h0,
    ASR_SCAN_ON = 2'h1,
    ASR_SCAN_UNUSED = 2'h2,
    ASR_SCAN_ERR = 2'h3
  } asr_scan_t;
  // ----------------------------------------------------------------
  // live status carried in from the converter core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fast_link_flag;
    asr_op_t operating_state_code;
    logic [4:0] buffer_fill_count;
    logic [3:0] sum_count;
    logic alarm_event;
    logic alarm_channel;
    logic scan_enabled;
    logic scan_error;
    logic sum_done;
    logic [15:0] chan0_sum;
    logic [15:0] chan1_sum;
  } asr_status_t;
endpackage : asr_pkg

// File: dv/asr_host.sv
// host model issuing single register reads and writes
`timescale 1ns/100ps
module asr_host (
  input wire logic clock_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in,
  output logic rd_en_out,
  output logic wr_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wr_data_out
);
  initial begin
    rd_en_out = 1'h0;
    wr_en_out = 1'h0;
    addr_out = 8'h00;
    wr_data_out = 8'h00;
  end
  // ------------
  // access task
  // ------------
  task automatic acc(input logic w, input logic [7:0] a,
                     output logic [7:0] d, output logic v);
    @(posedge clock_in);
    rd_en_out <= ~w;
    wr_en_out <= w;
    addr_out <= a;
    wr_data_out <= 8'hFF;
    @(posedge clock_in);
    rd_en_out <= 1'h0;
    wr_en_out <= 1'h0;
    addr_out <= ~a;
    wr_data_out <= 8'h00;
    @(posedge clock_in);
    d = rd_data_in;
    v = rd_valid_in;
  endtask : acc
endmodule : asr_host

// File: dv/testbench.sv
// self-checking bench for the status readback bank
`timescale 1ns/100ps
module testbench;
  logic clock_in = 1'h0;
  logic rst_in = 1'h1;
  logic soft_rst_in = 1'h0;
  asr_pkg::asr_status_t st = '0;
  logic rd_en, wr_en, rd_valid, v;
  logic [7:0] addr, wr_data, rd_data, d;
  logic [7:0] oa [6] = '{8'h02, 8'h03, 8'h08, 8'h09, 8'h0A, 8'h0B};
  logic [7:0] ex [6] = '{8'h0F, 8'h10, 8'hC3, 8'hA5, 8'h3C, 8'h5A};
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  initial forever #5 clock_in = ~clock_in;
  asr_bank u_asr_bank (.clock_in(clock_in), .rst_in(rst_in),
    .soft_rst_in(soft_rst_in), .status_in(st), .rd_en_in(rd_en),
    .wr_en_in(wr_en), .addr_in(addr), .wr_data_in(wr_data),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid));
  asr_host u_asr_host (.clock_in(clock_in), .rd_data_in(rd_data),
    .rd_valid_in(rd_valid), .rd_en_out(rd_en), .wr_en_out(wr_en),
    .addr_out(addr), .wr_data_out(wr_data));
  task automatic chk(input string n, input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    u_asr_host.acc(1'h0, a, d, v);
    chk($sformatf("reg %h", a), d, e);
    chk("valid", {7'h00, v}, 8'h01);
  endtask : rdc
  task automatic ev(input logic al, input logic sm);
    @(posedge clock_in);
    st.alarm_event <= al;
    st.sum_done <= sm;
    @(posedge clock_in);
    st.alarm_event <= 1'h0;
    st.sum_done <= 1'h0;
  endtask : ev
  task automatic summarize;
    $display("error_cnt %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  // -----
  // tests
  // -----
  initial begin
    repeat (2) @(posedge clock_in);
    rst_in <= 1'h0;
    for (int i = 0; i < 16; i++) rdc(8'(i), 8'h00);
    for (int i = 2; i < 5; i++) begin
      @(posedge clock_in);
      st.fast_link_flag <= i[0];
      st.operating_state_code <= asr_pkg::asr_op_t'(i[1:0]);
      rdc(8'h00, {5'h00, i[0], i[1:0]});
    end
    @(posedge clock_in);
    st.fast_link_flag <= 1'h1;
    st.operating_state_code <= asr_pkg::ASR_OP_UNUSED;
    rdc(8'h00, 8'h04);
    for (int i = 0; i < 25; i += 8) begin
      @(posedge clock_in);
      st.buffer_fill_count <= 5'(i);
      rdc(8'h01, (i > 16) ? 8'h10 : 8'(i));
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_in);
      st.scan_enabled <= i[1];
      st.scan_error <= i[0];
      rdc(8'h04, {5'h00, i[1] & i[0], i[1], 1'h0});
    end
    @(posedge clock_in);
    st.sum_count <= 4'hF;
    st.chan0_sum <= 16'hA5C3;
    st.chan1_sum <= 16'h5A3C;
    st.alarm_channel <= 1'h1;
    ev(1'h1, 1'h1);
    st.chan0_sum <= 16'h0000;
    st.chan1_sum <= 16'hFFFF;
    st.alarm_channel <= 1'h0;
    ev(1'h1, 1'h0);
    for (int i = 0; i < 6; i++) begin
      u_asr_host.acc(1'h1, oa[i], d, v);
      chk("write answer", {7'h00, v}, 8'h00);
      rdc(oa[i], ex[i]);
    end
    @(posedge clock_in);
    soft_rst_in <= 1'h1;
    @(posedge clock_in);
    soft_rst_in <= 1'h0;
    for (int i = 0; i < 6; i++) rdc(oa[i], 8'h00);
    summarize();
  end
endmodule : testbench
